// file: ppc_pkg.sv
// Package for the port pin control block: offsets, layouts, resets
package ppc_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] PPC_OFF_A_VALUE = 3'h0;
	localparam logic [2:0] PPC_OFF_A_DIR = 3'h1;
	localparam logic [2:0] PPC_OFF_C_ANALOG = 3'h2;
	localparam logic [2:0] PPC_OFF_C_PULLUP = 3'h3;
	localparam logic [2:0] PPC_OFF_OPTION = 3'h4;
	localparam logic [2:0] PPC_OFF_C_DIR = 3'h5;
	localparam logic [2:0] PPC_OFF_C_VALUE = 3'h6;
	// Widths
	localparam int PPC_A_W = 6;
	localparam int PPC_C_W = 8;
	// First port: bit 3 is input only, bits 7:6 absent
	localparam logic [5:0] PPC_A_LATCH_MASK = 6'h37;
	localparam logic [5:0] PPC_A_DIR_MASK = 6'h37;
	localparam logic [5:0] PPC_A_LATCH_RST = 6'h00;
	localparam logic [5:0] PPC_A_DIR_RST = 6'h37;
	localparam logic [7:0] PPC_A_DIR_FIXED_ONE = 8'h08;
	// Second port analog select per package variant
	localparam logic [7:0] PPC_ANALOG_MASK_LARGE = 8'hcf;
	localparam logic [7:0] PPC_ANALOG_MASK_SMALL = 8'h3f;
	localparam logic [7:0] PPC_ANALOG_RST = 8'hff;
	localparam logic [7:0] PPC_PULLUP_RST = 8'hff;
	localparam logic [7:0] PPC_C_DIR_RST = 8'hff;
	localparam logic [7:0] PPC_C_LATCH_RST = 8'h00;
	localparam logic [7:0] PPC_FULL_MASK = 8'hff;
	// Option register: global pull-up disable, active low enable
	localparam int PPC_OPT_PULLUP_DIS_BIT = 7;
	localparam logic [7:0] PPC_OPT_MASK = 8'h80;
	localparam logic [7:0] PPC_OPT_RST = 8'h80;
	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ppc_bus_req_t;
	// Drive of one port's pins
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} ppc_pin_drive_t;
endpackage

// file: ppc_reg_cell.sv
// Software register with a storage mask and a reset value
`timescale 1ns/100ps
module ppc_reg_cell
	import ppc_pkg::*;
#(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0,
	parameter logic [W-1:0] MASK = '1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Write side
	input wire logic i_we,
	input wire logic [W-1:0] i_d,
	// Stored value and its next value
	output logic [W-1:0] o_q,
	output logic [W-1:0] o_next
);
	logic [W-1:0] val_reg; // Held bits, absent bits kept at zero
	logic [W-1:0] val_next;

	// Absent bits never take a write
	always_comb begin
		val_next = val_reg;
		if (i_srst) begin
			val_next = RST & MASK;
		end else if (i_we) begin
			val_next = i_d & MASK;
		end
	end

	// Register only
	always_ff @(posedge i_clk_sys) begin
		val_reg <= val_next;
	end

	assign o_q = val_reg;
	assign o_next = val_next;
endmodule

// file: ppc_pin_sample.sv
// Pin level sampler with analog masking of the input buffer
`timescale 1ns/100ps
module ppc_pin_sample
	import ppc_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Pin levels and analog selection
	input wire logic [W-1:0] i_pins,
	input wire logic [W-1:0] i_analog,
	// Sampled digital levels
	output logic [W-1:0] o_level
);
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;

	// A disabled input buffer reads as zero, not as the pin
	always_comb begin
		level_next = i_pins & ~i_analog;
		if (i_srst) begin
			level_next = '0;
		end
	end

	// Register only
	always_ff @(posedge i_clk_sys) begin
		level_reg <= level_next;
	end

	assign o_level = level_reg;
endmodule

// file: ppc_port_ctrl.sv
// Top of the port pin control block: registers, pin drive, pull-ups
//
// Notes on behaviour
// - Value writes hit latch; reads return pins
// - Six pin bits; bit 3 read-only, top zero
// - Direction one is input, zero output; reset one
// - Direction bit 3 reads one, bits 7:6 zero
// - Analog select one disables digital input buffer
// - Analog select zero restores digital pin use
// - Analog bits present depend on package variant
// - Pull-up bits request pull-ups; reset to one
// - Global disable bit set forces pull-ups off
// - Output pins never get their pull-up
`timescale 1ns/100ps
module ppc_port_ctrl
	import ppc_pkg::*;
#(
	// One selects the larger package variant
	parameter bit P_LARGE_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// First port pins
	input wire logic [5:0] i_first_port_pin_bits,
	output logic [5:0] o_first_port_out,
	output logic [5:0] o_first_port_oe,
	// Second port pins
	input wire logic [7:0] i_second_port_pins,
	output logic [7:0] o_second_port_out,
	output logic [7:0] o_second_port_oe,
	output logic [7:0] o_second_port_pullup,
	output logic [7:0] o_second_port_analog
);
	// Variant dependent set of analog select bits
	localparam logic [7:0] ANALOG_MASK =
		P_LARGE_VARIANT ? PPC_ANALOG_MASK_LARGE : PPC_ANALOG_MASK_SMALL;

	// Request bundled for decoding
	ppc_bus_req_t req;

	// Register values and their next values
	logic [5:0] first_port_output_latch;
	logic [5:0] first_port_output_latch_next;
	logic [5:0] first_port_direction;
	logic [5:0] first_port_direction_next;
	logic [7:0] second_port_analog_select;
	logic [7:0] second_port_analog_select_next;
	logic [7:0] second_port_pullups;
	logic [7:0] second_port_pullups_next;
	logic [7:0] option_bits;
	logic [7:0] option_bits_next;
	logic [7:0] second_port_direction;
	logic [7:0] second_port_direction_next;
	logic [7:0] second_port_latch;
	logic [7:0] second_port_latch_next;

	// Sampled pin levels
	logic [5:0] first_port_level;
	logic [7:0] second_port_level;

	// Write enables per register
	logic we_a_value;
	logic we_a_dir;
	logic we_c_analog;
	logic we_c_pullup;
	logic we_option;
	logic we_c_dir;
	logic we_c_value;

	// Output flops
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	ppc_pin_drive_t first_drive_reg;
	ppc_pin_drive_t first_drive_next;
	ppc_pin_drive_t second_drive_reg;
	ppc_pin_drive_t second_drive_next;
	logic [7:0] pullup_reg;
	logic [7:0] pullup_next;
	logic [7:0] analog_reg;
	logic [7:0] analog_next;
	logic global_pullup_disable_n;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// Write decode
	always_comb begin
		we_a_value = 1'b0;
		we_a_dir = 1'b0;
		we_c_analog = 1'b0;
		we_c_pullup = 1'b0;
		we_option = 1'b0;
		we_c_dir = 1'b0;
		we_c_value = 1'b0;
		if (!req.wr) begin
			we_a_value = 1'b0;
		end else if (req.addr == PPC_OFF_A_VALUE) begin
			we_a_value = 1'b1;
		end else if (req.addr == PPC_OFF_A_DIR) begin
			we_a_dir = 1'b1;
		end else if (req.addr == PPC_OFF_C_ANALOG) begin
			we_c_analog = 1'b1;
		end else if (req.addr == PPC_OFF_C_PULLUP) begin
			we_c_pullup = 1'b1;
		end else if (req.addr == PPC_OFF_OPTION) begin
			we_option = 1'b1;
		end else if (req.addr == PPC_OFF_C_DIR) begin
			we_c_dir = 1'b1;
		end else if (req.addr == PPC_OFF_C_VALUE) begin
			we_c_value = 1'b1;
		end
	end

	// First port output latch; bit 3 has no storage
	ppc_reg_cell #(.W(6), .RST(PPC_A_LATCH_RST), .MASK(PPC_A_LATCH_MASK)) u_a_latch (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_a_value),
		.i_d(req.wdata[5:0]),
		.o_q(first_port_output_latch),
		.o_next(first_port_output_latch_next)
	);

	// First port direction, implemented bits reset to input
	ppc_reg_cell #(.W(6), .RST(PPC_A_DIR_RST), .MASK(PPC_A_DIR_MASK)) u_a_dir (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_a_dir),
		.i_d(req.wdata[5:0]),
		.o_q(first_port_direction),
		.o_next(first_port_direction_next)
	);

	// Analog select; absent bits per variant hold zero
	ppc_reg_cell #(.W(8), .RST(PPC_ANALOG_RST), .MASK(ANALOG_MASK)) u_c_analog (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_c_analog),
		.i_d(req.wdata),
		.o_q(second_port_analog_select),
		.o_next(second_port_analog_select_next)
	);

	// Pull-up requests, all eight reset on
	ppc_reg_cell #(.W(8), .RST(PPC_PULLUP_RST), .MASK(PPC_FULL_MASK)) u_c_pullup (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_c_pullup),
		.i_d(req.wdata),
		.o_q(second_port_pullups),
		.o_next(second_port_pullups_next)
	);

	// Option register holding the global pull-up disable
	ppc_reg_cell #(.W(8), .RST(PPC_OPT_RST), .MASK(PPC_OPT_MASK)) u_option (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_option),
		.i_d(req.wdata),
		.o_q(option_bits),
		.o_next(option_bits_next)
	);

	// Second port direction, needed to gate its pull-ups
	ppc_reg_cell #(.W(8), .RST(PPC_C_DIR_RST), .MASK(PPC_FULL_MASK)) u_c_dir (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_c_dir),
		.i_d(req.wdata),
		.o_q(second_port_direction),
		.o_next(second_port_direction_next)
	);

	// Second port output latch
	ppc_reg_cell #(.W(8), .RST(PPC_C_LATCH_RST), .MASK(PPC_FULL_MASK)) u_c_latch (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(we_c_value),
		.i_d(req.wdata),
		.o_q(second_port_latch),
		.o_next(second_port_latch_next)
	);

	// First port has no analog select, so nothing is masked
	ppc_pin_sample #(.W(6)) u_a_sample (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_pins(i_first_port_pin_bits),
		.i_analog(6'h00),
		.o_level(first_port_level)
	);

	// Analog pins read zero: their digital buffer is off
	ppc_pin_sample #(.W(8)) u_c_sample (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_pins(i_second_port_pins),
		.i_analog(second_port_analog_select),
		.o_level(second_port_level)
	);

	// Bit set means pull-ups are globally off
	assign global_pullup_disable_n = option_bits_next[PPC_OPT_PULLUP_DIS_BIT];

	// Read mux; data stand one cycle, zero otherwise and when unmapped
	always_comb begin
		rdata_next = 8'h00;
		if (!req.rd || i_srst) begin
			rdata_next = 8'h00;
		end else if (req.addr == PPC_OFF_A_VALUE) begin
			rdata_next = {2'b00, first_port_level};
		end else if (req.addr == PPC_OFF_A_DIR) begin
			rdata_next = {2'b00, first_port_direction} | PPC_A_DIR_FIXED_ONE;
		end else if (req.addr == PPC_OFF_C_ANALOG) begin
			rdata_next = second_port_analog_select;
		end else if (req.addr == PPC_OFF_C_PULLUP) begin
			rdata_next = second_port_pullups;
		end else if (req.addr == PPC_OFF_OPTION) begin
			rdata_next = option_bits;
		end else if (req.addr == PPC_OFF_C_DIR) begin
			rdata_next = second_port_direction;
		end else if (req.addr == PPC_OFF_C_VALUE) begin
			rdata_next = second_port_level;
		end
	end

	// Pin drive from next values, so pins follow a write with no extra lag
	always_comb begin
		first_drive_next.out = {2'b00, first_port_output_latch_next};
		first_drive_next.oe = {2'b00, ~first_port_direction_next & PPC_A_DIR_MASK};
		second_drive_next.out = second_port_latch_next;
		second_drive_next.oe = ~second_port_direction_next;
		// Pull-up needs its own bit, an input pin and the global gate
		pullup_next = second_port_pullups_next & second_port_direction_next;
		if (global_pullup_disable_n) begin
			pullup_next = 8'h00;
		end
		// Analog select zero hands the pin back to digital logic
		analog_next = second_port_analog_select_next;
		// Driver fight on analog pins is left to software
		if (i_srst) begin
			first_drive_next = '0;
			second_drive_next = '0;
			pullup_next = 8'h00;
			analog_next = PPC_ANALOG_RST & ANALOG_MASK;
		end
	end

	// Output registers only
	always_ff @(posedge i_clk_sys) begin
		rdata_reg <= rdata_next;
		first_drive_reg <= first_drive_next;
		second_drive_reg <= second_drive_next;
		pullup_reg <= pullup_next;
		analog_reg <= analog_next;
	end

	assign o_rdata = rdata_reg;
	assign o_first_port_out = first_drive_reg.out[5:0];
	assign o_first_port_oe = first_drive_reg.oe[5:0];
	assign o_second_port_out = second_drive_reg.out;
	assign o_second_port_oe = second_drive_reg.oe;
	assign o_second_port_pullup = pullup_reg;
	assign o_second_port_analog = analog_reg;

	// Checks on the behaviour above
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	// A read of the first port value
	sequence s_read_a_value;
		i_rd && (i_addr == PPC_OFF_A_VALUE);
	endsequence

	// A read of the first port direction
	sequence s_read_a_dir;
		i_rd && (i_addr == PPC_OFF_A_DIR);
	endsequence

	// A write of the first port value
	sequence s_write_a_value;
		i_wr && (i_addr == PPC_OFF_A_VALUE);
	endsequence

	a_latch_write: assert property (
		s_write_a_value |=> (o_first_port_out == ($past(i_wdata[5:0]) & PPC_A_LATCH_MASK))
	) else $error("value write did not reach latch");

	a_pin_read: assert property (
		s_read_a_value ##1 1'b1 |-> o_rdata == {2'b00, $past(first_port_level)}
	) else $error("value read not pin levels");

	a_bit3_ro: assert property (
		s_write_a_value ##1 1'b1 |-> (o_first_port_out[3] == 1'b0) && (o_first_port_oe[3] == 1'b0)
	) else $error("input only bit took a write");

	a_dir_fixed: assert property (
		s_read_a_dir |=> (o_rdata[3] == 1'b1) && (o_rdata[7:6] == 2'b00)
	) else $error("direction fixed bits wrong");

	a_dir_oe: assert property (
		##1 o_first_port_oe == (~first_port_direction & PPC_A_DIR_MASK)
	) else $error("output enable not from direction");

	a_analog_zero: assert property (
		##1 ((second_port_level & $past(second_port_analog_select)) == 8'h00)
	) else $error("analog pin read as digital");

	a_analog_mask: assert property (
		i_rd && (i_addr == PPC_OFF_C_ANALOG) |=> ((o_rdata & ~ANALOG_MASK) == 8'h00)
	) else $error("absent analog bit read as one");

	a_pullup_global: assert property (
		##1 option_bits[PPC_OPT_PULLUP_DIS_BIT] |-> (o_second_port_pullup == 8'h00)
	) else $error("pull-up on while globally disabled");

	a_pullup_output: assert property (
		##1 ((o_second_port_pullup & o_second_port_oe) == 8'h00)
	) else $error("pull-up on an output pin");

	a_pullup_follow: assert property (
		##1 !option_bits[PPC_OPT_PULLUP_DIS_BIT] |->
			(o_second_port_pullup == (second_port_pullups & second_port_direction))
	) else $error("pull-up does not follow request");

	// Pin drive must always mirror the held latch; the check is off while reset is high
	a_latch_mirror: assert property (
		(o_first_port_out == first_port_output_latch) &&
			(o_second_port_out == second_port_latch)
	) else $error("pin drive differs from latch");

	a_second_latch: assert property (
		i_wr && (i_addr == PPC_OFF_C_VALUE) |=> (o_second_port_out == $past(i_wdata))
	) else $error("second port write did not reach latch");

	a_analog_write: assert property (
		i_wr && (i_addr == PPC_OFF_C_ANALOG) |=>
			(o_second_port_analog == ($past(i_wdata) & ANALOG_MASK))
	) else $error("analog select write not applied");
endmodule

// file: ppc_pin_model.sv
// Model of the pins and the outside world around the port pin control block
`timescale 1ns/100ps
module ppc_pin_model
	import ppc_pkg::*;
(
	// Clock
	input wire logic i_clk_sys,
	// Level the outside world puts on pins that nobody drives
	input wire logic [7:0] i_ext_lvl,
	// First port drive from the block
	input wire logic [5:0] i_a_out,
	input wire logic [5:0] i_a_oe,
	// Second port drive, pull-ups and analog selection
	input wire logic [7:0] i_c_out,
	input wire logic [7:0] i_c_oe,
	input wire logic [7:0] i_c_pullup,
	input wire logic [7:0] i_c_analog,
	// Resolved pin levels
	output logic [5:0] o_a_pins,
	output logic [7:0] o_c_pins
);
	// Analog voltage seen digitally as noise, so a leaky input buffer shows up
	logic [7:0] noise_reg = 8'h5a;

	// Noise flips every cycle
	always @(posedge i_clk_sys) begin
		noise_reg <= ~noise_reg;
	end

	// Driver wins, then the pull-up, then analog source or outside level
	always_comb begin
		o_a_pins = (i_a_oe & i_a_out) | (~i_a_oe & i_ext_lvl[5:0]);
		o_c_pins = (i_c_oe & i_c_out) | (~i_c_oe & i_c_pullup)
			| (~i_c_oe & ~i_c_pullup & i_c_analog & noise_reg)
			| (~i_c_oe & ~i_c_pullup & ~i_c_analog & i_ext_lvl);
	end
endmodule

// file: ppc_port_ctrl_bench.sv
// Self-checking testbench of the port pin control block with a register model
`timescale 1ns/100ps
module ppc_port_ctrl_bench;
	import ppc_pkg::*;
	// Clock, reset and register port
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	// Pin side
	logic [7:0] ext_lvl = 8'h00;
	logic [5:0] a_out, a_oe, a_pins;
	logic [7:0] c_out, c_oe, c_pu, c_an_o, c_pins;
	// Smaller variant: read data and analog selection
	logic [7:0] rdata_small, c_an_small;
	// Model registers, kept as plain integers
	int a_lat, a_dir, c_an, c_pul, opt, c_dir, c_lat;
	int c_an_s; // Analog selection of the smaller variant
	// Counters and random state
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] seed = 32'haabe;
	logic [2:0] wa;
	logic [7:0] wd;

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	// Block under test, larger package variant
	ppc_port_ctrl #(.P_LARGE_VARIANT(1'b1)) dut (
		.i_clk_sys(clk_sys), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_first_port_pin_bits(a_pins), .o_first_port_out(a_out), .o_first_port_oe(a_oe),
		.i_second_port_pins(c_pins), .o_second_port_out(c_out), .o_second_port_oe(c_oe),
		.o_second_port_pullup(c_pu), .o_second_port_analog(c_an_o));

	// Pins and outside world
	ppc_pin_model pins (
		.i_clk_sys(clk_sys), .i_ext_lvl(ext_lvl), .i_a_out(a_out), .i_a_oe(a_oe),
		.i_c_out(c_out), .i_c_oe(c_oe), .i_c_pullup(c_pu), .i_c_analog(c_an_o),
		.o_a_pins(a_pins), .o_c_pins(c_pins));

	// Smaller package variant on the same bus and pins
	ppc_port_ctrl #(.P_LARGE_VARIANT(1'b0)) dut_small (
		.i_clk_sys(clk_sys), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata_small),
		.i_first_port_pin_bits(a_pins), .o_first_port_out(), .o_first_port_oe(),
		.i_second_port_pins(c_pins), .o_second_port_out(), .o_second_port_oe(),
		.o_second_port_pullup(), .o_second_port_analog(c_an_small));

	// Random source
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// One comparison, counted
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
			miscompares++;
		end
	endtask

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Reset from the next edge: three edges at start, two in mid-run
	task automatic do_reset;
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		a_lat = PPC_A_LATCH_RST;
		a_dir = PPC_A_DIR_RST;
		c_an = PPC_ANALOG_RST & PPC_ANALOG_MASK_LARGE;
		c_an_s = PPC_ANALOG_RST & PPC_ANALOG_MASK_SMALL;
		c_pul = PPC_PULLUP_RST;
		opt = PPC_OPT_RST;
		c_dir = PPC_C_DIR_RST;
		c_lat = PPC_C_LATCH_RST;
	endtask

	// One-cycle write; absent bits are dropped from the model
	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		case (a)
			PPC_OFF_A_VALUE: a_lat = d & PPC_A_LATCH_MASK;
			PPC_OFF_A_DIR: a_dir = d & PPC_A_DIR_MASK;
			PPC_OFF_C_ANALOG: begin
				c_an = d & PPC_ANALOG_MASK_LARGE;
				c_an_s = d & PPC_ANALOG_MASK_SMALL;
			end
			PPC_OFF_C_PULLUP: c_pul = d;
			PPC_OFF_OPTION: opt = d & PPC_OPT_MASK;
			PPC_OFF_C_DIR: c_dir = d;
			PPC_OFF_C_VALUE: c_lat = d;
			default: ; // Unmapped index, write lost
		endcase
	endtask

	// One-cycle read; data stand only in the following cycle
	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Expected read value from the model and the settled pins
	function automatic logic [7:0] exp_read(input logic [2:0] a);
		case (a)
			3'h0: return {2'b00, a_pins};
			3'h1: return 8'(a_dir) | PPC_A_DIR_FIXED_ONE;
			3'h2: return 8'(c_an);
			3'h3: return 8'(c_pul);
			3'h4: return 8'(opt);
			3'h5: return 8'(c_dir);
			3'h6: return c_pins & ~8'(c_an);
			default: return 8'h00;
		endcase
	endfunction

	// Compare every output and every register; pins need two edges to reach a read
	task automatic check_all;
		logic [7:0] d;
		repeat (2) @(posedge clk_sys);
		#1;
		check(8'(a_out), 8'(a_lat), "latch");
		check(8'(a_oe), 8'(~a_dir & PPC_A_DIR_MASK), "first oe");
		check(c_out, 8'(c_lat), "second out");
		check(c_oe, ~8'(c_dir), "second oe");
		check(c_pu, 8'(c_pul & c_dir) & (opt[7] ? 8'h00 : 8'hff), "pullup");
		check(c_an_o, 8'(c_an), "analog");
		check(c_an_small, 8'(c_an_s), "small analog");
		for (int i = 0; i < 8; i++) begin
			reg_read(3'(i), d);
			check(d, exp_read(3'(i)), "read");
			if (i == 2) begin
				check(rdata_small, 8'(c_an_s), "small analog read");
			end
		end
	endtask

	// Hang guard, far beyond the expected length of the run
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	// Main sequence: reset values, random traffic, a second reset
	initial begin
		do_reset;
		check_all;
		for (int n = 0; n < 300; n++) begin
			seed = xorshift(seed);
			ext_lvl <= seed[15:8];
			wa = seed[2:0];
			wd = seed[23:16];
			// Analog pins are always left as inputs
			if (wa == PPC_OFF_C_ANALOG) wd &= 8'(c_dir);
			if (wa == PPC_OFF_C_DIR) wd |= 8'(c_an | c_an_s);
			reg_write(wa, wd);
			check_all;
		end
		do_reset;
		check_all;
		tally_and_finish;
	end
endmodule
